/* File: core/pin_sync.sv */
// pin_sync: two-stage synchroniser for the serial clock and data pins
// assumes inputs are asynchronous to mclk_i
`default_nettype none

module pin_sync (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [serial_bus_pkg::SYNC_WIDTH-1:0] async_i,
	output logic [serial_bus_pkg::SYNC_WIDTH-1:0] sync_o
);
	import serial_bus_pkg::*;

	logic [SYNC_WIDTH-1:0] stage1;

	// idle bus lines are pulled high
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			stage1 <= '1;
			sync_o <= '1;
		end else begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end

endmodule // pin_sync

`default_nettype wire

/* File: core/serial_bus_pkg.sv */
// serial_bus_pkg: constants, states and carriers of the serial bus framing block
// assumes a single system clock of 125 MHz on mclk_i
`default_nettype none

package serial_bus_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int SCK_HALF_NS = 256;
	localparam int SCK_HALF_CYCLES = SCK_HALF_NS / CLK_PERIOD_NS;
	localparam int ACK_WAIT_NS = 4000;
	localparam int ACK_WAIT_CYCLES = (ACK_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HALF_CNT_W = 6;
	localparam int ACK_CNT_W = 9;
	localparam logic [HALF_CNT_W-1:0] HALF_LAST = HALF_CNT_W'(SCK_HALF_CYCLES - 1);
	localparam logic [ACK_CNT_W-1:0] ACK_WAIT_LAST = ACK_CNT_W'(ACK_WAIT_CYCLES - 1);

	// ----------------------------------------
	// framing and field positions
	// ----------------------------------------
	localparam int BYTE_BITS = 8;
	localparam logic [2:0] LAST_BIT_INDEX = 3'h7;
	localparam int SYNC_WIDTH = 2;
	localparam int SYNC_SCK_BIT = 0;
	localparam int SYNC_SDA_BIT = 1;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [BYTE_BITS-1:0] SLAVE_ADDR_RESET = 8'h00;
	localparam logic [BYTE_BITS-1:0] SHIFT_RESET = 8'h00;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		XFER_IDLE = 2'b00,
		XFER_SHIFT = 2'b01,
		XFER_ACK = 2'b10,
		XFER_BUSY = 2'b11
	} xfer_state_type;

	typedef enum logic [1:0] {
		KIND_DATA = 2'b00,
		KIND_COMMAND = 2'b01,
		KIND_ADDRESS = 2'b10
	} byte_kind_type;

	typedef struct packed {
		logic selected;
		logic address_match;
		logic free_detected_flag;
		logic command_detected_flag;
		byte_kind_type byte_kind;
		logic ack_detected;
		logic ack_timeout;
		logic busy;
	} status_type;

	localparam status_type STATUS_RESET = '0;

	// byte kind from the conditions seen before it
	function automatic byte_kind_type classify_byte(input logic free_seen, input logic cmd_seen);
		byte_kind_type kind;
		kind = KIND_DATA;
		if (free_seen && cmd_seen) begin
			kind = KIND_ADDRESS;
		end else if (cmd_seen) begin
			kind = KIND_COMMAND;
		end
		return kind;
	endfunction

endpackage

`default_nettype wire

/* File: core/two_wire_serial_bus_framing.sv */
// two_wire_serial_bus_framing: serial channel, 3-wire mode and 2-wire bus mode
// assumes pins are pulled up outside; data pin is open-drain in bus mode
`default_nettype none

module two_wire_serial_bus_framing (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic serial_channel_enable_i,
	input wire logic bus_mode_i,
	input wire logic master_mode_i,
	input wire logic address_wake_select_i,
	input wire logic ack_enable_i,
	input wire logic busy_enable_i,
	input wire logic busy_release_i,
	input wire logic release_req_i,
	input wire logic command_req_i,
	input wire logic done_flag_clear_i,
	input wire logic slave_address_wr_i,
	input wire logic [serial_bus_pkg::BYTE_BITS-1:0] slave_address_data_i,
	input wire logic serial_shift_register_wr_i,
	input wire logic [serial_bus_pkg::BYTE_BITS-1:0] serial_shift_register_data_i,
	input wire logic serial_clock_pin_i,
	input wire logic data_bus_pin_a_i,
	output logic serial_clock_pin_o,
	output logic serial_clock_pin_oe_o,
	output logic data_bus_pin_a_o,
	output logic data_bus_pin_a_oe_o,
	output logic serial_out_o,
	output logic [serial_bus_pkg::BYTE_BITS-1:0] serial_shift_register_o,
	output logic [serial_bus_pkg::BYTE_BITS-1:0] slave_address_o,
	output logic transfer_done_flag_o,
	output logic transfer_interrupt_o,
	output serial_bus_pkg::status_type status_o
);
	import serial_bus_pkg::*;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [SYNC_WIDTH-1:0] pins_sync;
	logic sck_s;
	logic sda_s;
	logic sck_prev;
	logic sda_prev;
	logic sck_rise;
	logic sck_fall;
	logic cond_window;
	logic free_seen;
	logic cmd_seen;
	logic clock_idle;
	logic start_ok;
	logic byte_done;
	logic [BYTE_BITS-1:0] new_byte;
	byte_kind_type new_kind;
	logic new_match;
	logic raise_irq;
	xfer_state_type state;
	logic [2:0] bit_cnt;
	logic out_latch;
	logic sck_out;
	logic [HALF_CNT_W-1:0] half_cnt;
	logic cond_low;
	logic rel_pending;
	logic [HALF_CNT_W-1:0] cond_cnt;
	logic ack_drive;
	logic busy_hold;
	logic busy_drive;
	logic ack_waiting;
	logic [ACK_CNT_W-1:0] ack_cnt;
	logic next_sda_low;

	// ----------------------------------------
	// pin sampling and edges
	// ----------------------------------------
	pin_sync u_pin_sync (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.async_i({data_bus_pin_a_i, serial_clock_pin_i}),
		.sync_o(pins_sync)
	);

	assign sck_s = pins_sync[SYNC_SCK_BIT];
	assign sda_s = pins_sync[SYNC_SDA_BIT];

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			sck_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			sck_prev <= sck_s;
			sda_prev <= sda_s;
		end
	end

	assign sck_rise = sck_s & ~sck_prev;
	assign sck_fall = ~sck_s & sck_prev;

	// conditions only between bytes, clock high
	assign cond_window = bus_mode_i & serial_channel_enable_i & sck_s & sck_prev
		& ((state == XFER_IDLE) | ((state == XFER_SHIFT) & (bit_cnt == 3'h0)));
	// bus-free: data rises under high clock
	assign free_seen = cond_window & sda_s & ~sda_prev;
	// command: data falls under high clock
	assign cmd_seen = cond_window & ~sda_s & sda_prev;

	// ----------------------------------------
	// transfer start and byte completion
	// ----------------------------------------
	assign clock_idle = master_mode_i ? sck_out : sck_s;
	// start needs enable and idle high clock
	assign start_ok = serial_shift_register_wr_i & serial_channel_enable_i
		& (state == XFER_IDLE) & clock_idle;
	assign byte_done = (state == XFER_SHIFT) & sck_rise & (bit_cnt == LAST_BIT_INDEX)
		& serial_channel_enable_i;
	assign new_byte = {serial_shift_register_o[BYTE_BITS-2:0], sda_s};
	assign new_kind = classify_byte(status_o.free_detected_flag, status_o.command_detected_flag);
	// compare address byte to own address
	assign new_match = (new_byte == slave_address_o);
	assign raise_irq = byte_done & (~(address_wake_select_i & bus_mode_i)
		| ((classify_byte(status_o.free_detected_flag, status_o.command_detected_flag)
		== KIND_ADDRESS) & new_match));

	// ----------------------------------------
	// transfer sequencer
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i || !serial_channel_enable_i) begin
			state <= XFER_IDLE;
			bit_cnt <= 3'h0;
		end else begin
			case (state)
				XFER_IDLE: begin
					bit_cnt <= 3'h0;
					// a write only counts while enabled
					if (start_ok) begin
						state <= XFER_SHIFT;
					end
				end
				XFER_SHIFT: begin
					if (sck_rise) begin
						bit_cnt <= bit_cnt + 3'h1;
					end
					// stop by itself after eight bits
					if (byte_done) begin
						state <= bus_mode_i ? XFER_ACK : XFER_IDLE;
					end
				end
				XFER_ACK: begin
					if (sck_rise) begin
						state <= XFER_BUSY;
					end
				end
				XFER_BUSY: begin
					if (sck_rise && sda_s) begin
						state <= XFER_IDLE;
					end
				end
				default: begin
					state <= XFER_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// shift register
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			serial_shift_register_o <= SHIFT_RESET;
			out_latch <= 1'b1;
		end else if (start_ok) begin
			serial_shift_register_o <= serial_shift_register_data_i;
			out_latch <= 1'b1;
		end else if (state == XFER_SHIFT) begin
			// drive on falling edge, sample on rising edge
			if (sck_fall) begin
				out_latch <= serial_shift_register_o[BYTE_BITS-1];
			end
			if (sck_rise) begin
				serial_shift_register_o <= new_byte;
			end
		end else if (state != XFER_SHIFT) begin
			out_latch <= 1'b1;
		end
	end

	// ----------------------------------------
	// master clock generator
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i || !serial_channel_enable_i || !master_mode_i) begin
			sck_out <= 1'b1;
			half_cnt <= '0;
		end else if ((state != XFER_IDLE) || !sck_out) begin
			// clocks run until busy is gone
			if (half_cnt == HALF_LAST) begin
				half_cnt <= '0;
				sck_out <= ~sck_out;
			end else begin
				half_cnt <= half_cnt + 1'b1;
			end
		end else begin
			half_cnt <= '0;
		end
	end

	// ----------------------------------------
	// master bus-free and command conditions
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i || !serial_channel_enable_i || !master_mode_i || !bus_mode_i) begin
			cond_low <= 1'b0;
			rel_pending <= 1'b0;
			cond_cnt <= '0;
		end else if (state == XFER_IDLE && sck_out) begin
			if (release_req_i) begin
				// pull low, then release under high clock
				cond_low <= 1'b1;
				rel_pending <= 1'b1;
				cond_cnt <= '0;
			end else if (command_req_i) begin
				cond_low <= 1'b1;
				rel_pending <= 1'b0;
			end else if (rel_pending) begin
				if (cond_cnt == HALF_LAST) begin
					cond_low <= 1'b0;
					rel_pending <= 1'b0;
				end else begin
					cond_cnt <= cond_cnt + 1'b1;
				end
			end
		end else if (sck_fall) begin
			cond_low <= 1'b0;
			rel_pending <= 1'b0;
		end
	end

	// ----------------------------------------
	// acknowledge and busy drive
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i || !serial_channel_enable_i || !bus_mode_i) begin
			ack_drive <= 1'b0;
			busy_hold <= 1'b0;
			busy_drive <= 1'b0;
		end else begin
			if (sck_fall) begin
				// one-clock ack pulse after the byte
				ack_drive <= (state == XFER_ACK) & ack_enable_i;
				// busy moves on falling edges only
				busy_drive <= (state == XFER_BUSY) & busy_hold;
			end
			if (busy_release_i) begin
				busy_hold <= 1'b0;
			end else if (state == XFER_ACK && sck_rise) begin
				busy_hold <= busy_enable_i & ~master_mode_i;
			end else if (state == XFER_IDLE) begin
				busy_hold <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// acknowledge timeout
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i || !serial_channel_enable_i || start_ok) begin
			ack_waiting <= 1'b0;
			ack_cnt <= '0;
		end else if (byte_done && bus_mode_i) begin
			ack_waiting <= 1'b1;
			ack_cnt <= '0;
		end else if (ack_waiting) begin
			// wait a preset time for the ack
			if (status_o.ack_detected || ack_cnt == ACK_WAIT_LAST) begin
				ack_waiting <= 1'b0;
			end else begin
				ack_cnt <= ack_cnt + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// own address register
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			slave_address_o <= SLAVE_ADDR_RESET;
		end else if (slave_address_wr_i) begin
			slave_address_o <= slave_address_data_i;
		end
	end

	// ----------------------------------------
	// status, selection and byte kind
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i || !serial_channel_enable_i) begin
			status_o <= STATUS_RESET;
		end else begin
			status_o.busy <= busy_hold;
			if (start_ok) begin
				status_o.ack_detected <= 1'b0;
				status_o.ack_timeout <= 1'b0;
			end else if (state == XFER_ACK && sck_rise && !sda_s) begin
				status_o.ack_detected <= 1'b1;
			end else if (ack_waiting && ack_cnt == ACK_WAIT_LAST && !status_o.ack_detected) begin
				status_o.ack_timeout <= 1'b1;
			end
			if (byte_done) begin
				// address after bus-free and command conditions, command after command condition alone, else data
				status_o.byte_kind <= new_kind;
				status_o.command_detected_flag <= 1'b0;
				if (new_kind == KIND_ADDRESS) begin
					status_o.free_detected_flag <= 1'b0;
					status_o.address_match <= new_match;
					status_o.selected <= new_match;
				end
			end
			if (free_seen) begin
				status_o.free_detected_flag <= 1'b1;
				status_o.command_detected_flag <= 1'b0;
				status_o.selected <= 1'b0;
			end
			if (cmd_seen) begin
				status_o.command_detected_flag <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// done flag and interrupt
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			transfer_done_flag_o <= 1'b0;
			transfer_interrupt_o <= 1'b0;
		end else begin
			transfer_interrupt_o <= raise_irq;
			if (raise_irq) begin
				transfer_done_flag_o <= 1'b1;
			end else if (done_flag_clear_i) begin
				transfer_done_flag_o <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// pin drivers
	// ----------------------------------------
	// open-drain data: low or released
	assign next_sda_low = bus_mode_i & serial_channel_enable_i
		& (((state == XFER_SHIFT) & ~out_latch) | ack_drive | busy_drive | cond_low);

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			data_bus_pin_a_o <= 1'b0;
			data_bus_pin_a_oe_o <= 1'b0;
			serial_out_o <= 1'b1;
			serial_clock_pin_o <= 1'b1;
			serial_clock_pin_oe_o <= 1'b0;
		end else begin
			data_bus_pin_a_o <= 1'b0;
			data_bus_pin_a_oe_o <= next_sda_low;
			serial_out_o <= out_latch;
			serial_clock_pin_o <= sck_out;
			serial_clock_pin_oe_o <= master_mode_i & serial_channel_enable_i;
		end
	end

endmodule // two_wire_serial_bus_framing

`default_nettype wire

/* File: testbench/bus_master_model.sv */
// bus_master_model: far-side bus master driving clock and open-drain data
// assumes lines resolved with pull-ups by the bench
`default_nettype none

module bus_master_model (
	input wire logic sda_i,
	output var logic scl_o,
	output var logic sda_low_o
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HALF = 32;
	int busy_clks;
	// ----------------------------------------
	// line control
	// ----------------------------------------
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
		busy_clks = 0;
	end
	task automatic free_cond();
		sda_low_o = 1'b1;
		#HALF;
		sda_low_o = 1'b0;
		#HALF;
	endtask
	task automatic cmd_cond();
		sda_low_o = 1'b1;
		#HALF;
	endtask
	task automatic slot(input logic low);
		scl_o = 1'b0;
		#8;
		sda_low_o = low;
		#(HALF - 8);
		scl_o = 1'b1;
		#HALF;
	endtask
	task automatic xfer(input logic [7:0] b, output logic [7:0] rx, output logic ack);
		int i;
		#3;
		for (i = 7; i >= 0; i--) begin
			slot(!b[i]);
			rx[i] = sda_i;
		end
		slot(1'b0);
		ack = !sda_i;
		busy_clks = 0;
		for (i = 0; i < 64; i++) begin
			slot(1'b0);
			busy_clks++;
			if (sda_i) break;
		end
	endtask
endmodule // bus_master_model

`default_nettype wire

/* File: testbench/serial_bus_props.sv */
// serial_bus_props: concurrent checks on the framing block ports
// assumes one clock domain, bound to two_wire_serial_bus_framing
`default_nettype none

module serial_bus_props (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic serial_channel_enable_i,
	input wire logic bus_mode_i,
	input wire logic master_mode_i,
	input wire logic address_wake_select_i,
	input wire logic data_bus_pin_a_o,
	input wire logic data_bus_pin_a_oe_o,
	input wire logic serial_clock_pin_oe_o,
	input wire logic transfer_done_flag_o,
	input wire logic transfer_interrupt_o,
	input wire serial_bus_pkg::status_type status_o
);
	import serial_bus_pkg::*;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_irq_pulse;
		transfer_interrupt_o |=> !transfer_interrupt_o;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt too long");
	property p_done;
		transfer_interrupt_o |-> ##[0:1] transfer_done_flag_o;
	endproperty
	a_done: assert property (p_done) else $error("done flag not set");
	property p_irq_en;
		transfer_interrupt_o |-> $past(serial_channel_enable_i);
	endproperty
	a_irq_en: assert property (p_irq_en) else $error("interrupt while disabled");
	property p_dis;
		!serial_channel_enable_i [*2] |-> status_o == STATUS_RESET && !transfer_interrupt_o;
	endproperty
	a_dis: assert property (p_dis) else $error("activity while disabled");
	property p_open_drain;
		data_bus_pin_a_oe_o |-> !data_bus_pin_a_o;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("data line driven high");
	property p_clk_slave;
		!master_mode_i [*2] |-> !serial_clock_pin_oe_o;
	endproperty
	a_clk_slave: assert property (p_clk_slave) else $error("slave drives clock");
	property p_wake;
		bus_mode_i && address_wake_select_i && transfer_interrupt_o
			|-> ##[0:1] status_o.address_match;
	endproperty
	a_wake: assert property (p_wake) else $error("wake interrupt without match");
	property p_sel_rise;
		$rose(status_o.selected) |-> status_o.address_match && status_o.byte_kind == KIND_ADDRESS;
	endproperty
	a_sel_rise: assert property (p_sel_rise) else $error("selected without address");
	property p_sel_hold;
		status_o.selected && serial_channel_enable_i ##1 !status_o.selected
			|-> status_o.free_detected_flag;
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("selection lost early");
	property p_free;
		$rose(status_o.free_detected_flag) |-> !status_o.selected && !status_o.command_detected_flag;
	endproperty
	a_free: assert property (p_free) else $error("bus-free did not reset state");
endmodule // serial_bus_props

bind two_wire_serial_bus_framing serial_bus_props u_serial_bus_props (
	.mclk_i, .rst_i, .serial_channel_enable_i, .bus_mode_i, .master_mode_i,
	.address_wake_select_i, .data_bus_pin_a_o, .data_bus_pin_a_oe_o, .serial_clock_pin_oe_o,
	.transfer_done_flag_o, .transfer_interrupt_o, .status_o
);

`default_nettype wire

/* File: testbench/tb.sv */
// tb: self-checking bench for the two-wire serial bus framing block
// assumes bus_master_model on the far side and the bound checker
`default_nettype none

module tb;
	import serial_bus_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic en = 1'b0;
	logic bmode = 1'b1;
	logic mmode = 1'b0;
	logic wake = 1'b0;
	logic bsyen = 1'b0;
	logic bsyrel = 1'b0;
	logic clr = 1'b0;
	logic sa_wr = 1'b0;
	logic sr_wr = 1'b0;
	logic [7:0] sa_d = 8'h00;
	logic [7:0] sr_d = 8'h00;
	logic relreq = 1'b0;
	logic cmdreq = 1'b0;
	logic ack_en = 1'b1;
	logic scl_o, scl_oe, sda_o, sda_oe, so, irq, done, ack;
	logic [7:0] sr_q, sa_q, rx;
	logic [7:0] so_cap = 8'h00;
	status_type st;
	wire logic m_scl;
	wire logic m_low;
	wire logic scl = (scl_oe ? scl_o : 1'b1) & m_scl;
	wire logic sda = (sda_oe ? sda_o : 1'b1) & !m_low;
	int err_total = 0;
	int n_tests = 0;
	int n_irq = 0;
	int n_rise = 0;
	// wake, kind, byte, selected, interrupt
	logic [12:0] rows [8] = '{
		{1'h0, 2'h2, 8'h5A, 1'h1, 1'h1}, {1'h0, 2'h1, 8'h3C, 1'h1, 1'h1},
		{1'h0, 2'h0, 8'hC3, 1'h1, 1'h1}, {1'h0, 2'h2, 8'h11, 1'h0, 1'h1},
		{1'h1, 2'h2, 8'h11, 1'h0, 1'h0}, {1'h1, 2'h0, 8'h22, 1'h0, 1'h0},
		{1'h1, 2'h2, 8'h5A, 1'h1, 1'h1}, {1'h1, 2'h1, 8'h44, 1'h1, 1'h0}};

	always #4 mclk = ~mclk;
	always @(posedge mclk) if (irq === 1'b1) n_irq <= n_irq + 1;
	always @(posedge scl) begin
		so_cap <= {so_cap[6:0], so};
		n_rise <= n_rise + 1;
	end

	two_wire_serial_bus_framing u_two_wire_serial_bus_framing (
		.mclk_i(mclk), .rst_i(rst), .serial_channel_enable_i(en), .bus_mode_i(bmode),
		.master_mode_i(mmode), .address_wake_select_i(wake), .ack_enable_i(ack_en),
		.busy_enable_i(bsyen), .busy_release_i(bsyrel), .release_req_i(relreq),
		.command_req_i(cmdreq), .done_flag_clear_i(clr), .slave_address_wr_i(sa_wr),
		.slave_address_data_i(sa_d), .serial_shift_register_wr_i(sr_wr),
		.serial_shift_register_data_i(sr_d), .serial_clock_pin_i(scl), .data_bus_pin_a_i(sda),
		.serial_clock_pin_o(scl_o), .serial_clock_pin_oe_o(scl_oe), .data_bus_pin_a_o(sda_o),
		.data_bus_pin_a_oe_o(sda_oe), .serial_out_o(so), .serial_shift_register_o(sr_q),
		.slave_address_o(sa_q), .transfer_done_flag_o(done), .transfer_interrupt_o(irq),
		.status_o(st));
	bus_master_model u_bus_master_model (.sda_i(sda), .scl_o(m_scl), .sda_low_o(m_low));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_byte({7'h00, got}, {7'h00, exp});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask
	task automatic tally_and_finish();
		$display("errors=%0d tests=%0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wait_irq(input int n);
		for (int k = 0; k < 3000 && n_irq < n; k++) tick(1);
		if (n_irq < n) begin
			err_total++;
			tally_and_finish();
		end
	endtask
	task automatic bus_byte(input logic [1:0] kind, input logic [7:0] b);
		sr_d = 8'hFF;
		pulse(sr_wr);
		if (kind == 2'h2) u_bus_master_model.free_cond();
		if (kind != 2'h0) u_bus_master_model.cmd_cond();
		u_bus_master_model.xfer(b, rx, ack);
		tick(12);
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		logic [1:0] kind;
		logic [7:0] b;
		logic esel, eirq;
		int c;
		tick(16);
		chk_byte(sa_q, SLAVE_ADDR_RESET);
		chk_bit(so, 1'b1);
		rst = 1'b0;
		en = 1'b1;
		sa_d = 8'h5A;
		pulse(sa_wr);
		chk_byte(sa_q, 8'h5A);
		for (int r = 0; r < 8; r++) begin
			{wake, kind, b, esel, eirq} = rows[r];
			c = n_irq;
			bus_byte(kind, b);
			chk_byte(sr_q, b);
			chk_byte({6'h00, st.byte_kind}, {6'h00, kind});
			chk_bit(st.selected, esel);
			if (esel) chk_bit(ack, 1'b1);
			chk_bit(st.ack_detected, 1'b1);
			chk_byte(8'(u_bus_master_model.busy_clks), 8'h01);
			chk_byte(8'(n_irq - c), {7'h00, eirq});
		end
		wake = 1'b0;
		ack_en = 1'b0;
		bus_byte(2'h0, 8'h3C);
		chk_bit(ack, 1'b0);
		chk_bit(st.ack_detected, 1'b0);
		tick(500);
		chk_bit(st.ack_timeout, 1'b1);
		ack_en = 1'b1;
		bsyen = 1'b1;
		fork
			bus_byte(2'h0, 8'h69);
			begin
				tick(150);
				chk_bit(st.busy, 1'b1);
				pulse(bsyrel);
			end
		join
		chk_bit(u_bus_master_model.busy_clks > 3, 1'b1);
		chk_bit(u_bus_master_model.busy_clks < 64, 1'b1);
		chk_bit(st.busy, 1'b0);
		u_bus_master_model.free_cond();
		tick(8);
		chk_bit(st.selected, 1'b0);
		chk_bit(st.free_detected_flag, 1'b1);
		bsyen = 1'b0;
		bmode = 1'b0;
		mmode = 1'b1;
		en = 1'b0;
		tick(2);
		c = n_rise;
		sr_d = 8'h77;
		pulse(sr_wr);
		en = 1'b1;
		tick(300);
		chk_byte(8'(n_rise - c), 8'h00);
		pulse(clr);
		chk_bit(done, 1'b0);
		c = n_irq;
		sr_d = 8'hA5;
		pulse(sr_wr);
		wait_irq(c + 1);
		tick(4);
		chk_byte(so_cap, 8'hA5);
		chk_byte(sr_q, 8'hFF);
		chk_bit(done, 1'b1);
		pulse(clr);
		chk_bit(done, 1'b0);
		bmode = 1'b1;
		pulse(relreq);
		tick(10);
		chk_bit(sda, 1'b0);
		chk_bit(scl, 1'b1);
		tick(40);
		chk_bit(st.free_detected_flag, 1'b1);
		chk_bit(st.command_detected_flag, 1'b0);
		pulse(cmdreq);
		tick(10);
		chk_bit(sda, 1'b0);
		chk_bit(st.command_detected_flag, 1'b1);
		tally_and_finish();
	end
endmodule // tb

`default_nettype wire
